// ---- pkg/analog_ref_map.vh ----
// offsets, field positions, reset values, format codes and timing counts
// assumes byte addressing on a 32-bit axi4-lite bus, one register per word
`ifndef ANALOG_REF_MAP_VH
`define ANALOG_REF_MAP_VH

`define REG_AI1_FMT 8'h00
`define REG_AI2_FMT 8'h04
`define REG_AI1_SCALE 8'h08
`define REG_AI1_OFFSET 8'h0C
`define REG_MAX_SPEED 8'h10
`define REG_MIN_SPEED 8'h14
`define REG_PRESET1 8'h18
`define REG_SWF_SET 8'h1C
`define REG_SWF_VIEW 8'h20
`define REG_IRQ_STATUS 8'h24
`define REG_IRQ_MASK 8'h28
`define REG_AI1_REF 8'h2C
`define REG_AI2_REF 8'h30
`define REG_SPEED 8'h34

`define FMT_UNI_V 4'h0
`define FMT_BIDIR_V 4'h1
`define FMT_MA_0_20 4'h2
`define FMT_4_20_TRIP 4'h3
`define FMT_4_20_PRESET 4'h4
`define FMT_20_4_TRIP 4'h5
`define FMT_20_4_PRESET 4'h6
`define FMT_INV_V 4'h7
`define FMT_POT 4'h8

`define RST_AI1_FMT 4'h8
`define RST_AI2_FMT 4'h0
`define RST_SCALE 16'h03E8
`define RST_OFFSET 16'h0000
`define RST_MAX_SPEED 16'h01F4
`define RST_MIN_SPEED 16'h0000
`define RST_PRESET1 16'h0064

`define SCALE_MAX 16'h4E20
`define OFFSET_LIM 16'h1388

`define ST_AI1_LOSS 0
`define ST_AI2_LOSS 1
`define ST_DERATE 2
`define ST_W 3
`define VIEW_DERATED_BIT 8

`define CODE_FULL 32'h00000FFF
`define CODE_4MA 12'h333
`define CODE_3MA 12'h266
`define CODE_SPAN_4_20 32'h00000CCC
`define PCT_FULL 32'h000003E8
`define REF_LIM 32'h00007530

`define SWF_MIN 6'h04
`define SWF_MAX 6'h20
`define SWF_RST 6'h08
`define SWF_STEP 6'h02

`define CLK_MHZ 100
`define DERATE_STEP_US 1000

`endif

// ---- design/analog_ref_channel.v ----
// one analog reference input: format decode, offset, scaling, loop-loss detect
// assumes level and pot codes already synchronised, 12-bit, full scale 10 v or 20 ma
`timescale 1ns/1ps
`include "analog_ref_map.vh"

module analog_ref_channel
(
	input wire clk_sys,
	input wire reset_n,
	input wire [11:0] level_code,
	input wire [11:0] pot_code,
	input wire [3:0] fmt,
	input wire [15:0] scale,
	input wire [15:0] offset,
	output reg [15:0] ref_q,
	output reg loss_q,
	output reg trip_q
);

	reg [11:0] src;
	reg [31:0] lin;
	reg signed [31:0] diff;
	reg signed [31:0] sc;
	reg is_420;
	reg is_inv;

	always @*
	begin
		src = (fmt == `FMT_POT) ? pot_code : level_code; // R9
		is_420 = (fmt >= `FMT_4_20_TRIP) && (fmt <= `FMT_20_4_PRESET);
		is_inv = (fmt == `FMT_INV_V) || (fmt == `FMT_20_4_TRIP) || (fmt == `FMT_20_4_PRESET);
		// 0-10 v, 0-20 ma and pot share one linear span
		lin = ({20'h00000, src} * `PCT_FULL) / `CODE_FULL; // R8 R14
		if (is_420)
		begin
			if (src < `CODE_4MA)
				lin = 32'h00000000;
			else
				lin = ({20'h00000, src - `CODE_4MA} * `PCT_FULL) / `CODE_SPAN_4_20; // R14
		end
		diff = $signed(lin) - {{16{offset[15]}}, offset}; // R13
		sc = (diff * $signed({16'h0000, scale})) / $signed(`PCT_FULL); // R13
		// inversion after scaling so a reference at or below zero gives full speed
		if (is_inv)
			sc = $signed(`PCT_FULL) - sc; // R7 R14
		if (sc > $signed(`REF_LIM))
			sc = $signed(`REF_LIM);
		else if (sc < -$signed(`REF_LIM))
			sc = -$signed(`REF_LIM);
	end

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			ref_q <= 16'h0000;
			loss_q <= 1'b0;
			trip_q <= 1'b0;
		end
		else
		begin
			ref_q <= sc[15:0];
			loss_q <= is_420 && (src < `CODE_3MA); // R5
			trip_q <= is_420 && (src < `CODE_3MA) &&
				((fmt == `FMT_4_20_TRIP) || (fmt == `FMT_20_4_TRIP)); // R4 R6
		end
	end

endmodule

// ---- design/switch_freq_derate.v ----
// effective switching frequency, stepped down while the heatsink is too hot
// assumes over_temp already synchronised; steps back up once it clears
`timescale 1ns/1ps
`include "analog_ref_map.vh"

module switch_freq_derate
#(
	parameter STEP_CYCLES = 100000,
	parameter CW = 24
)
(
	input wire clk_sys,
	input wire reset_n,
	input wire over_temp,
	input wire [5:0] set_khz,
	output reg [5:0] actual_q,
	output wire derated,
	output reg derate_begin_q
);

	reg [CW-1:0] tick_q;
	wire tick;

	assign tick = (tick_q == STEP_CYCLES[CW-1:0] - 1'b1);
	assign derated = (actual_q < set_khz); // R12

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			tick_q <= {CW{1'b0}};
			actual_q <= `SWF_RST;
			derate_begin_q <= 1'b0;
		end
		else
		begin
			tick_q <= tick ? {CW{1'b0}} : tick_q + 1'b1;
			derate_begin_q <= 1'b0;
			// a lowered setting takes effect at once, without waiting a step
			if (actual_q > set_khz)
				actual_q <= set_khz; // R11
			else if (tick && over_temp && actual_q > `SWF_MIN)
			begin
				actual_q <= (actual_q - `SWF_STEP < `SWF_MIN) ? `SWF_MIN
					: actual_q - `SWF_STEP; // R12
				derate_begin_q <= !derated; // R12
			end
			else if (tick && !over_temp && actual_q < set_khz)
				actual_q <= (actual_q + `SWF_STEP > set_khz) ? set_khz
					: actual_q + `SWF_STEP;
		end
	end

endmodule

// ---- design/analog_reference_format_select.v ----
// analog reference to speed command, with format select, loop loss and derating
// assumes an axi4-lite master on clk_sys and analog codes arriving asynchronously
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "analog_ref_map.vh"

// Behaviour
// R1: unipolar volt format holds minimum speed when the reference is at or below zero.
// R2: a reference of full scale commands exactly the maximum speed setting.
// R3: bidirectional volt format reverses rotation when the reference is negative.
// R4: 4-20mA trip format raises the loop-loss fault below 3mA.
// R5: current formats with fallback run at preset speed 1 below 3mA.
// R6: 20-4mA format also has a trip variant raising loop-loss below 3mA.
// R7: inverted 10-0V format runs at maximum speed when reference is at or below zero.
// R8: both inputs accept a 0-20mA current format.
// R9: input 1 offers an integrated potentiometer format, its reset default.
// R10: input 2 formats are 0-10V, 0-20mA, 4-20 and 20-4mA variants; default 0-10V.
// R11: maximum switching frequency is settable 4 to 32 kHz, default 8 kHz.
// R12: heatsink overheat lowers switching frequency, readable, with a derated flag.
// R13: reference equals applied level minus offset, multiplied by the scaling factor.
// R14: each format maps its span linearly to 0-100%; inverted spans run high to zero.
module analog_reference_format_select
#(
	parameter DERATE_STEP_CYCLES = `DERATE_STEP_US * `CLK_MHZ
)
(
	input wire clk_sys,
	input wire reset_n,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [11:0] ai1_code,
	input wire [11:0] ai2_code,
	input wire [11:0] pot_code,
	input wire heatsink_over_temp,
	output reg [15:0] speed_cmd_q,
	output reg speed_reverse_q,
	output wire loop_loss_fault,
	output wire [5:0] actual_switch_freq_view,
	output wire switch_freq_derated_flag,
	output wire irq
);

	// pins: two flops each; codes are assumed to move slowly against clk_sys
	reg [11:0] ai1_s1_q, ai1_s2_q, ai2_s1_q, ai2_s2_q, pot_s1_q, pot_s2_q;
	reg hot_s1_q, hot_s2_q;

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			ai1_s1_q <= 12'h000;
			ai1_s2_q <= 12'h000;
			ai2_s1_q <= 12'h000;
			ai2_s2_q <= 12'h000;
			pot_s1_q <= 12'h000;
			pot_s2_q <= 12'h000;
			hot_s1_q <= 1'b0;
			hot_s2_q <= 1'b0;
		end
		else
		begin
			ai1_s1_q <= ai1_code;
			ai1_s2_q <= ai1_s1_q;
			ai2_s1_q <= ai2_code;
			ai2_s2_q <= ai2_s1_q;
			pot_s1_q <= pot_code;
			pot_s2_q <= pot_s1_q;
			hot_s1_q <= heatsink_over_temp;
			hot_s2_q <= hot_s1_q;
		end
	end

	// configuration
	reg [3:0] ai1_fmt_q, ai2_fmt_q;
	reg [15:0] scale_q, offset_q, max_speed_q, min_speed_q, preset1_q;
	reg [5:0] swf_set_q;
	reg [`ST_W-1:0] status_q, mask_q;

	// two reference channels; input 2 has no scaling or offset of its own
	wire [31:0] ch_ref;
	wire [1:0] ch_loss;
	wire [1:0] ch_trip;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_ch
			analog_ref_channel u_ch
			(
				.clk_sys(clk_sys),
				.reset_n(reset_n),
				.level_code(gi == 0 ? ai1_s2_q : ai2_s2_q),
				.pot_code(pot_s2_q),
				.fmt(gi == 0 ? ai1_fmt_q : ai2_fmt_q),
				.scale(gi == 0 ? scale_q : `RST_SCALE),
				.offset(gi == 0 ? offset_q : `RST_OFFSET),
				.ref_q(ch_ref[gi*16 +: 16]),
				.loss_q(ch_loss[gi]),
				.trip_q(ch_trip[gi])
			);
		end
	endgenerate

	wire derate_begin;

	switch_freq_derate #(.STEP_CYCLES(DERATE_STEP_CYCLES)) u_derate
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.over_temp(hot_s2_q),
		.set_khz(swf_set_q),
		.actual_q(actual_switch_freq_view),
		.derated(switch_freq_derated_flag),
		.derate_begin_q(derate_begin)
	);

	// a latched trip stays until software clears it
	assign loop_loss_fault = status_q[`ST_AI1_LOSS] | status_q[`ST_AI2_LOSS]; // R4 R6
	assign irq = |(status_q & mask_q);

	// speed command from input 1
	localparam [31:0] pct_full = `PCT_FULL;
	reg signed [15:0] eff;
	reg [15:0] mag;
	reg rev;
	reg [31:0] prod;
	reg [15:0] spd;

	always @*
	begin
		eff = $signed(ch_ref[15:0]);
		rev = 1'b0;
		if (ai1_fmt_q == `FMT_BIDIR_V && eff < 0)
		begin
			rev = 1'b1; // R3
			mag = -eff;
		end
		else if (eff <= 0)
			mag = 16'h0000; // R1
		else
			mag = eff;
		if (mag > `PCT_FULL)
			mag = pct_full[15:0]; // R7
		prod = ({16'h0000, max_speed_q} * {16'h0000, mag}) / `PCT_FULL; // R2
		spd = prod[15:0];
		if (spd < min_speed_q)
			spd = min_speed_q; // R1
	end

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			speed_cmd_q <= 16'h0000;
			speed_reverse_q <= 1'b0;
		end
		else if (ch_loss[0] && !ch_trip[0])
		begin
			speed_cmd_q <= preset1_q; // R5
			speed_reverse_q <= 1'b0;
		end
		else if (status_q[`ST_AI1_LOSS] || ch_trip[0])
		begin
			speed_cmd_q <= 16'h0000; // R4
			speed_reverse_q <= 1'b0;
		end
		else
		begin
			speed_cmd_q <= spd;
			speed_reverse_q <= rev; // R3
		end
	end

	// axi4-lite write: address and data taken in either order
	reg aw_full_q, w_full_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire [31:0] bmask;
	wire do_write;
	wire [31:0] nv;

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign nv = wdata_q & bmask;

	function fmt_ok2;
		input [3:0] f;
		begin
			fmt_ok2 = (f == `FMT_UNI_V) || ((f >= `FMT_MA_0_20) && (f <= `FMT_20_4_PRESET));
		end
	endfunction

	reg wr_hit;

	always @*
	begin
		wr_hit = 1'b1;
		if (awaddr_q == `REG_AI1_FMT) wr_hit = 1'b1;
		else if (awaddr_q == `REG_AI2_FMT) wr_hit = 1'b1;
		else if (awaddr_q == `REG_AI1_SCALE) wr_hit = 1'b1;
		else if (awaddr_q == `REG_AI1_OFFSET) wr_hit = 1'b1;
		else if (awaddr_q == `REG_MAX_SPEED) wr_hit = 1'b1;
		else if (awaddr_q == `REG_MIN_SPEED) wr_hit = 1'b1;
		else if (awaddr_q == `REG_PRESET1) wr_hit = 1'b1;
		else if (awaddr_q == `REG_SWF_SET) wr_hit = 1'b1;
		else if (awaddr_q == `REG_IRQ_STATUS) wr_hit = 1'b1;
		else if (awaddr_q == `REG_IRQ_MASK) wr_hit = 1'b1;
		else wr_hit = 1'b0;
	end

	wire [`ST_W-1:0] st_set;
	wire [`ST_W-1:0] st_clr;

	assign st_set = {derate_begin, ch_trip[1], ch_trip[0]};
	assign st_clr = (do_write && awaddr_q == `REG_IRQ_STATUS) ? nv[`ST_W-1:0] : {`ST_W{1'b0}};

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			ai1_fmt_q <= `RST_AI1_FMT; // R9
			ai2_fmt_q <= `RST_AI2_FMT; // R10
			scale_q <= `RST_SCALE;
			offset_q <= `RST_OFFSET;
			max_speed_q <= `RST_MAX_SPEED;
			min_speed_q <= `RST_MIN_SPEED;
			preset1_q <= `RST_PRESET1;
			swf_set_q <= `SWF_RST; // R11
			status_q <= {`ST_W{1'b0}};
			mask_q <= {`ST_W{1'b0}};
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_q)
			begin
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid && !w_full_q)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
				// out-of-range values are dropped; scale and offset limits apply to the written bytes, not the merged value
				if (awaddr_q == `REG_AI1_FMT && wstrb_q[0] && nv[3:0] <= `FMT_POT)
					ai1_fmt_q <= nv[3:0]; // R8 R9
				else if (awaddr_q == `REG_AI2_FMT && wstrb_q[0] && fmt_ok2(nv[3:0]))
					ai2_fmt_q <= nv[3:0]; // R10
				else if (awaddr_q == `REG_AI1_SCALE && nv[15:0] <= `SCALE_MAX)
					scale_q <= (scale_q & ~bmask[15:0]) | nv[15:0]; // R13
				else if (awaddr_q == `REG_AI1_OFFSET)
				begin
					if ($signed(nv[15:0]) <= $signed(`OFFSET_LIM) &&
						$signed(nv[15:0]) >= -$signed(`OFFSET_LIM))
						offset_q <= (offset_q & ~bmask[15:0]) | nv[15:0]; // R13
				end
				else if (awaddr_q == `REG_MAX_SPEED)
					max_speed_q <= (max_speed_q & ~bmask[15:0]) | nv[15:0];
				else if (awaddr_q == `REG_MIN_SPEED)
					min_speed_q <= (min_speed_q & ~bmask[15:0]) | nv[15:0];
				else if (awaddr_q == `REG_PRESET1)
					preset1_q <= (preset1_q & ~bmask[15:0]) | nv[15:0];
				else if (awaddr_q == `REG_SWF_SET && wstrb_q[0] &&
					nv[5:0] >= `SWF_MIN && nv[5:0] <= `SWF_MAX && nv[7:6] == 2'b00)
					swf_set_q <= nv[5:0]; // R11
				else if (awaddr_q == `REG_IRQ_MASK)
					mask_q <= (mask_q & ~bmask[`ST_W-1:0]) | nv[`ST_W-1:0];
			end
			// a new event in the clearing cycle survives the clear
			status_q <= (status_q & ~st_clr) | st_set; // R4 R6 R12
		end
	end

	// axi4-lite read
	reg [31:0] rd_data;
	reg rd_hit;

	assign s_axi_arready = !s_axi_rvalid;

	always @*
	begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		if (s_axi_araddr[7:2] == `REG_AI1_FMT >> 2) rd_data = {28'h0, ai1_fmt_q};
		else if (s_axi_araddr[7:2] == `REG_AI2_FMT >> 2) rd_data = {28'h0, ai2_fmt_q};
		else if (s_axi_araddr[7:2] == `REG_AI1_SCALE >> 2) rd_data = {16'h0, scale_q};
		else if (s_axi_araddr[7:2] == `REG_AI1_OFFSET >> 2)
			rd_data = {{16{offset_q[15]}}, offset_q};
		else if (s_axi_araddr[7:2] == `REG_MAX_SPEED >> 2) rd_data = {16'h0, max_speed_q};
		else if (s_axi_araddr[7:2] == `REG_MIN_SPEED >> 2) rd_data = {16'h0, min_speed_q};
		else if (s_axi_araddr[7:2] == `REG_PRESET1 >> 2) rd_data = {16'h0, preset1_q};
		else if (s_axi_araddr[7:2] == `REG_SWF_SET >> 2)
		begin
			rd_data = {26'h0, swf_set_q};
			rd_data[`VIEW_DERATED_BIT] = switch_freq_derated_flag; // R12
		end
		else if (s_axi_araddr[7:2] == `REG_SWF_VIEW >> 2)
		begin
			rd_data = {26'h0, actual_switch_freq_view}; // R12
			rd_data[`VIEW_DERATED_BIT] = switch_freq_derated_flag;
		end
		else if (s_axi_araddr[7:2] == `REG_IRQ_STATUS >> 2) rd_data = {29'h0, status_q};
		else if (s_axi_araddr[7:2] == `REG_IRQ_MASK >> 2) rd_data = {29'h0, mask_q};
		else if (s_axi_araddr[7:2] == `REG_AI1_REF >> 2)
			rd_data = {{16{ch_ref[15]}}, ch_ref[15:0]};
		else if (s_axi_araddr[7:2] == `REG_AI2_REF >> 2)
			rd_data = {{16{ch_ref[31]}}, ch_ref[31:16]};
		else if (s_axi_araddr[7:2] == `REG_SPEED >> 2)
			rd_data = {15'h0, speed_reverse_q, speed_cmd_q};
		else rd_hit = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ---- testbench/analog_ref_checker.sv ----
// port checker for the analog reference block: bus timing, switching frequency, loop loss
// assumes it is bound to the top module, all signals on clk_sys
`timescale 1ns/1ps

module analog_ref_checker
(
	input wire clk_sys,
	input wire reset_n,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire loop_loss_fault,
	input wire [5:0] actual_switch_freq_view,
	input wire switch_freq_derated_flag,
	input wire irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response withdrawn early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_ar_gate;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	a_ar_gate: assert property (p_ar_gate) else $error("arready not inverse of rvalid");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_swf_range;
		actual_switch_freq_view >= 6'h04 && actual_switch_freq_view <= 6'h20;
	endproperty
	a_swf_range: assert property (p_swf_range) else $error("switching frequency out of range");
	property p_derated_low;
		switch_freq_derated_flag |-> actual_switch_freq_view <= 6'h1E;
	endproperty
	a_derated_low: assert property (p_derated_low) else $error("derated flag at full rate");
	// a trip is sticky: only a status write may end it
	property p_fault_clear;
		$fell(loop_loss_fault) |-> s_axi_bvalid;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without write");
	c_trip: cover property ($rose(loop_loss_fault));
	c_derate: cover property ($rose(switch_freq_derated_flag));
	c_irq: cover property ($rose(irq));
endmodule

// ---- testbench/analog_front_end.sv ----
// front end model: turns a per-mille level into a 12-bit converter code
// assumes full scale 10 v or 20 ma; codes change a few ns after the edge, not on it
`timescale 1ns/1ps

module analog_front_end
(
	input wire clk_sys,
	input wire [9:0] ai1_pm,
	input wire [9:0] ai2_pm,
	input wire [9:0] pot_pm,
	input wire hot_req,
	output logic [11:0] ai1_code,
	output logic [11:0] ai2_code,
	output logic [11:0] pot_code,
	output logic heatsink_over_temp
);
	function automatic logic [11:0] to_code(input logic [9:0] pm);
		int v;
		v = pm * 4095 / 1000;
		return v[11:0];
	endfunction
	initial
	begin
		ai1_code = 12'h000;
		ai2_code = 12'h000;
		pot_code = 12'hFFF;
		heatsink_over_temp = 1'b0;
	end
	// skewed off the edge so the block's synchronisers see truly async data
	always @(posedge clk_sys)
	begin
		#3;
		ai1_code <= to_code(ai1_pm);
		ai2_code <= to_code(ai2_pm);
		pot_code <= to_code(pot_pm);
		heatsink_over_temp <= hot_req;
	end
endmodule

// ---- testbench/analog_reference_format_select_tb_top.sv ----
// top bench: register bus, format, loop loss and derating scenarios
// assumes the checker and front end model compile first; derate step cut to 16 cycles
`timescale 1ns/1ps
`include "analog_ref_map.vh"

module analog_reference_format_select_tb_top;
	logic clk_sys, reset_n, hot_req, irq, heatsink_over_temp;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrv, brv;
	logic [11:0] ai1_code, ai2_code, pot_code;
	logic [9:0] ai1_pm, ai2_pm, pot_pm;
	logic speed_reverse_q, loop_loss_fault, switch_freq_derated_flag;
	logic [15:0] speed_cmd_q;
	logic [5:0] actual_switch_freq_view;
	int num_errors = 0;
	int compares = 0;
	int i;
	analog_reference_format_select #(.DERATE_STEP_CYCLES(16)) dut_u (.clk_sys(clk_sys),
		.reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.ai1_code(ai1_code), .ai2_code(ai2_code), .pot_code(pot_code),
		.heatsink_over_temp(heatsink_over_temp), .speed_cmd_q(speed_cmd_q),
		.speed_reverse_q(speed_reverse_q), .loop_loss_fault(loop_loss_fault),
		.actual_switch_freq_view(actual_switch_freq_view),
		.switch_freq_derated_flag(switch_freq_derated_flag), .irq(irq));
	analog_front_end afe_u (.clk_sys(clk_sys), .ai1_pm(ai1_pm), .ai2_pm(ai2_pm), .pot_pm(pot_pm),
		.hot_req(hot_req), .ai1_code(ai1_code), .ai2_code(ai2_code), .pot_code(pot_code),
		.heatsink_over_temp(heatsink_over_temp));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task final_report;
		begin
			$display("compares %0d mismatches %0d", compares, num_errors);
			if (num_errors == 0 && compares > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			compares++;
			if (seen !== exp)
			begin
				num_errors++;
				$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// ready is sampled at the falling edge, so the release lands right after the taking edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		begin
			ta = 1'b0;
			tw = 1'b0;
			@(posedge clk_sys);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(ta && tw))
			begin
				@(negedge clk_sys);
				ta = ta | (s_axi_awvalid & s_axi_awready);
				tw = tw | (s_axi_wvalid & s_axi_wready);
				@(posedge clk_sys);
				if (ta)
					s_axi_awvalid <= 1'b0;
				if (tw)
					s_axi_wvalid <= 1'b0;
			end
			do
				@(negedge clk_sys);
			while (s_axi_bvalid !== 1'b1);
			brv = s_axi_bresp;
			@(posedge clk_sys);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a);
		begin
			@(posedge clk_sys);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do
				@(negedge clk_sys);
			while (!(s_axi_arvalid && s_axi_arready));
			@(posedge clk_sys);
			s_axi_arvalid <= 1'b0;
			do
				@(negedge clk_sys);
			while (s_axi_rvalid !== 1'b1);
			rdv = s_axi_rdata;
			rrv = s_axi_rresp;
			@(posedge clk_sys);
			s_axi_rready <= 1'b0;
		end
	endtask
	task settle;
		repeat (8) @(posedge clk_sys);
	endtask
	task ai1(input logic [3:0] f, input logic [9:0] pm);
		begin
			wr(`REG_AI1_FMT, {28'h0000000, f});
			ai1_pm <= pm;
			settle;
		end
	endtask
	task spd(input logic [15:0] s, input logic r);
		begin
			check({16'h0000, speed_cmd_q}, {16'h0000, s});
			check({31'h00000000, speed_reverse_q}, {31'h00000000, r});
		end
	endtask
	task t_reset;
		begin
			rd(`REG_AI1_FMT);
			check(rdv, 32'h00000008);
			rd(`REG_AI2_FMT);
			check(rdv, 32'h00000000);
			rd(`REG_SWF_SET);
			check(rdv, 32'h00000008);
			rd(8'h3C);
			check({30'h00000000, rrv}, 32'h00000002);
			wr(8'h3C, 32'h00000001);
			check({30'h00000000, brv}, 32'h00000002);
			settle;
			spd(16'h01F4, 1'b0);
			$display("test reset done");
		end
	endtask
	task t_volt;
		begin
			wr(`REG_MIN_SPEED, 32'h00000032);
			ai1(`FMT_UNI_V, 10'h000);
			spd(16'h0032, 1'b0);
			ai1(`FMT_UNI_V, 10'h3E8);
			spd(16'h01F4, 1'b0);
			wr(`REG_AI1_SCALE, 32'h000007D0);
			wr(`REG_AI1_OFFSET, 32'h00000064);
			ai1(`FMT_UNI_V, 10'h1F4);
			spd(16'h018F, 1'b0);
			wr(`REG_AI1_SCALE, 32'h00004E21);
			rd(`REG_AI1_SCALE);
			check(rdv, 32'h000007D0);
			wr(`REG_AI1_OFFSET, 32'h000001F4);
			ai1(`FMT_BIDIR_V, 10'h000);
			spd(16'h01F4, 1'b1);
			ai1(`FMT_BIDIR_V, 10'h3E8);
			spd(16'h01F4, 1'b0);
			wr(`REG_AI1_SCALE, 32'h000003E8);
			wr(`REG_AI1_OFFSET, 32'h00000000);
			ai1(`FMT_INV_V, 10'h000);
			spd(16'h01F4, 1'b0);
			ai1(`FMT_INV_V, 10'h1F4);
			spd(16'h00FA, 1'b0);
			$display("test voltage formats done");
		end
	endtask
	task t_current;
		begin
			ai1(`FMT_MA_0_20, 10'h1F4);
			spd(16'h00F9, 1'b0);
			ai1(`FMT_4_20_PRESET, 10'h2BC);
			spd(16'h0138, 1'b0);
			ai1(`FMT_20_4_PRESET, 10'h2BC);
			spd(16'h00BC, 1'b0);
			ai1(`FMT_4_20_PRESET, 10'h08C);
			spd(16'h0064, 1'b0);
			ai1(`FMT_20_4_PRESET, 10'h08C);
			spd(16'h0064, 1'b0);
			check({31'h00000000, loop_loss_fault}, 32'h00000000);
			$display("test current formats done");
		end
	endtask
	// trip shows the fault either way; the interrupt follows mask bit m and stays low when m is clear
	task trip_case(input logic [3:0] f, input logic m);
		begin
			wr(`REG_IRQ_MASK, {31'h00000000, m});
			ai1(f, 10'h08C);
			check({31'h00000000, loop_loss_fault}, 32'h00000001);
			check({31'h00000000, irq}, {31'h00000000, m});
			spd(16'h0000, 1'b0);
			ai1_pm <= 10'h2BC;
			settle;
			check({31'h00000000, loop_loss_fault}, 32'h00000001);
			wr(`REG_IRQ_STATUS, 32'h00000001);
			@(posedge clk_sys);
			check({31'h00000000, loop_loss_fault}, 32'h00000000);
			check({31'h00000000, irq}, 32'h00000000);
			$display("test trip done");
		end
	endtask
	task t_ai2;
		logic [3:0] bad [3];
		begin
			bad = '{4'h1, 4'h7, 4'h8};
			foreach (bad[k])
			begin
				wr(`REG_AI2_FMT, {28'h0000000, bad[k]});
				rd(`REG_AI2_FMT);
				check(rdv, 32'h00000000);
			end
			wr(`REG_AI2_FMT, 32'h00000002);
			rd(`REG_AI2_FMT);
			check(rdv, 32'h00000002);
			ai2_pm <= 10'h3E8;
			settle;
			rd(`REG_AI2_REF);
			check(rdv, 32'h000003E8);
			$display("test input two done");
		end
	endtask
	task t_swf;
		begin
			wr(`REG_SWF_SET, 32'h00000028);
			wr(`REG_SWF_SET, 32'h00000002);
			rd(`REG_SWF_SET);
			check(rdv, 32'h00000008);
			wr(`REG_SWF_SET, 32'h00000020);
			for (i = 0; i < 600 && actual_switch_freq_view !== 6'h20; i++)
				@(posedge clk_sys);
			check({26'h0000000, actual_switch_freq_view}, 32'h00000020);
			wr(`REG_IRQ_MASK, 32'h00000004);
			hot_req <= 1'b1;
			for (i = 0; i < 100 && switch_freq_derated_flag !== 1'b1; i++)
				@(posedge clk_sys);
			check({31'h00000000, switch_freq_derated_flag}, 32'h00000001);
			rd(`REG_SWF_VIEW);
			check(rdv, 32'h0000011E);
			rd(`REG_SWF_SET);
			check(rdv, 32'h00000120);
			check({31'h00000000, irq}, 32'h00000001);
			hot_req <= 1'b0;
			for (i = 0; i < 600 && switch_freq_derated_flag !== 1'b0; i++)
				@(posedge clk_sys);
			check({26'h0000000, actual_switch_freq_view}, 32'h00000020);
			wr(`REG_IRQ_STATUS, 32'h00000004);
			@(posedge clk_sys);
			check({31'h00000000, irq}, 32'h00000000);
			$display("test switching frequency done");
		end
	endtask
	initial
	begin
		reset_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		hot_req = 1'b0;
		ai1_pm = 10'h000;
		ai2_pm = 10'h000;
		pot_pm = 10'h3E8;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset;
		t_volt;
		t_current;
		trip_case(`FMT_4_20_TRIP, 1'b1);
		trip_case(`FMT_20_4_TRIP, 1'b0);
		t_ai2;
		t_swf;
		final_report;
	end
	// whole run is under a thousand cycles; this only cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		final_report;
	end
endmodule

bind analog_reference_format_select analog_ref_checker chk_u (.clk_sys(clk_sys),
	.reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.loop_loss_fault(loop_loss_fault), .actual_switch_freq_view(actual_switch_freq_view),
	.switch_freq_derated_flag(switch_freq_derated_flag), .irq(irq));
